// ===== hw/sas_pkg.sv
package sas_pkg;

  localparam int CLK_PERIOD_NS = 8;

  // Sampling and per-bit time units, least times so rounded up
  localparam int SAMPLE_UNIT_NS  = 64;
  localparam int SAMPLE_UNIT_CYC =
    (SAMPLE_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BIT_UNIT_NS     = 32;
  localparam int BIT_UNIT_CYC    =
    (BIT_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CAL_SLOT_NS     = 48;
  localparam int CAL_SLOT_CYC    =
    (CAL_SLOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_CAL_NS    = 20000;
  localparam int RESET_CAL_CYC   =
    (RESET_CAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int RES_BITS  = 10;
  localparam int NUM_CH    = 24;
  localparam int NUM_STD   = 16;
  localparam int NUM_EXT   = 8;
  localparam int FIFO_DEPTH = 32;

  // Physical addresses
  localparam logic [15:0] PA_RESULT   = 16'hFEA0;
  localparam logic [15:0] PA_RESULT2  = 16'hF0A0;
  localparam logic [15:0] PA_EOC_IC   = 16'hFF98;
  localparam logic [15:0] PA_OVR_IC   = 16'hFF9A;
  localparam logic [15:0] PA_CONTROL  = 16'hFFA0;
  // Short 8-bit addresses, with extended-space flag
  localparam logic [7:0]  SA_RESULT   = 8'h50;
  localparam logic [7:0]  SA_RESULT2  = 8'h50;
  localparam logic [7:0]  SA_EOC_IC   = 8'hCC;
  localparam logic [7:0]  SA_OVR_IC   = 8'hCD;
  localparam logic [7:0]  SA_CONTROL  = 8'hD0;

  localparam logic [15:0] RST_RESULT  = 16'h0000;
  localparam logic [15:0] RST_RESULT2 = 16'h0000;
  localparam logic [15:0] RST_EOC_IC  = 16'h0000;
  localparam logic [15:0] RST_OVR_IC  = 16'h0000;
  localparam logic [15:0] RST_CONTROL = 16'h0000;

  // Control register fields
  localparam int CTL_CH_LSB    = 0;
  localparam int CTL_CH_W      = 5;
  localparam int CTL_MODE_LSB  = 5;
  localparam int CTL_START     = 7;
  localparam int CTL_BUSY      = 8;
  localparam int CTL_WAIT_RD   = 9;
  localparam int CTL_INJ_EN    = 10;
  localparam int CTL_CTC_LSB   = 12;
  localparam int CTL_STC_LSB   = 14;

  // Interrupt control register fields
  localparam int IC_FLAG = 7;
  localparam int IC_EN   = 6;

  // Result register fields
  localparam int RES_CH_LSB = 12;

  typedef enum logic [1:0] {
    MODE_SINGLE      = 2'h0,
    MODE_SINGLE_CONT = 2'h1,
    MODE_SCAN        = 2'h2,
    MODE_SCAN_CONT   = 2'h3
  } sas_mode_t;

  typedef enum logic [5:0] {
    ST_RESET_CAL = 6'h01,
    ST_IDLE      = 6'h02,
    ST_SAMPLE    = 6'h04,
    ST_CAL       = 6'h08,
    ST_CONV      = 6'h10,
    ST_DONE      = 6'h20
  } sas_state_t;

endpackage : sas_pkg

// ===== hw/sas_fifo.sv
`timescale 1ns/1ps
module sas_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  assign in_ready  = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr_r];

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule : sas_fifo

// ===== hw/sas_adc_sequencer.sv
// Functional notes
// - Ten-bit results, twenty-four inputs, sixteen plus eight
// - Sample first, then resolve one bit per step
// - Sample and bit times set by software
// - Overrun flag when unread result is replaced
// - Wait-for-read mode holds next conversion
// - Unused analog pins stay digital inputs
// - Four modes; single converts once, stops
// - Single continuous repeats without software
// - Auto-scan converts channel range in sequence
// - Auto-scan continuous restarts sequence forever
// - Injected channel converted in auto-scan continuous mode only, sequence left untouched
// - End-of-conversion request feeds event transfer unit
// - Calibration after reset and during operation
// - Calibration slot lies inside conversion cycle
// - Per-pin bit disconnects digital input stage
// - Registers hit by physical or short address
`timescale 1ns/1ps
module sas_adc_sequencer (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] sfr_phys_addr,
  input  wire logic [7:0]  sfr_short_addr,
  input  wire logic        sfr_short_mode,
  input  wire logic        sfr_ext_space,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [15:0] sfr_wdata,
  output logic      [15:0] sfr_rdata_r,
  input  wire logic        inject_req,
  input  wire logic [4:0]  inject_ch,
  input  wire logic        cmp_in,
  input  wire logic [23:0] ain_pin_in,
  input  wire logic [15:0] analog_port_digital_input_disable,
  input  wire logic [7:0]  port1_digital_input_disable,
  output logic      [23:0] dig_in_r,
  output logic      [4:0]  amux_ch_r,
  output logic             sample_en_r,
  output logic             cal_en_r,
  output logic      [9:0]  dac_code_r,
  output logic             eoc_irq_r,
  output logic             ovr_irq_r,
  output logic             event_transfer_req_r
);

  function automatic logic sas_hit(
    input logic [15:0] pa,
    input logic [7:0]  sa,
    input logic        sm,
    input logic        ex,
    input logic [15:0] ref_pa,
    input logic [7:0]  ref_sa,
    input logic        ref_ex
  );
    return sm ? ((sa == ref_sa) && (ex == ref_ex)) : (pa == ref_pa);
  endfunction : sas_hit

  localparam logic [11:0] SAMPLE_UNIT = 12'(sas_pkg::SAMPLE_UNIT_CYC);
  localparam logic [11:0] BIT_UNIT    = 12'(sas_pkg::BIT_UNIT_CYC);
  localparam logic [11:0] CAL_SLOT    = 12'(sas_pkg::CAL_SLOT_CYC);
  localparam logic [11:0] RESET_CAL   = 12'(sas_pkg::RESET_CAL_CYC);
  localparam int          MSB         = sas_pkg::RES_BITS - 1;
  localparam int          DIS_W       = sas_pkg::NUM_STD + sas_pkg::NUM_EXT;

  // Pin synchronisers
  logic [23:0] pin_s1_r;
  logic [23:0] pin_s2_r;
  logic        cmp_s1_r;
  logic        cmp_s2_r;

  // Registers
  logic [15:0] ctrl_r;
  logic [15:0] eoc_ic_r;
  logic [15:0] ovr_ic_r;
  logic [15:0] result_r;
  logic [15:0] result2_r;
  logic        unread_r;

  // Sequencer
  sas_pkg::sas_state_t state_r;
  sas_pkg::sas_state_t state_nxt;
  logic [11:0] timer_r;
  logic [11:0] timer_nxt;
  logic [3:0]  bit_r;
  logic [3:0]  bit_nxt;
  logic [9:0]  dac_nxt;
  logic [4:0]  cur_ch_r;
  logic [4:0]  cur_ch_nxt;
  logic [4:0]  amux_nxt;
  logic        inj_pend_r;
  logic [4:0]  inj_ch_r;
  logic        inj_active_r;
  logic        inj_active_nxt;
  logic        inj_take;
  logic        start_clr;

  // Address decode
  wire hit_res  = sas_hit(sfr_phys_addr, sfr_short_addr, sfr_short_mode,
                          sfr_ext_space, sas_pkg::PA_RESULT,
                          sas_pkg::SA_RESULT, 1'b0);
  wire hit_res2 = sas_hit(sfr_phys_addr, sfr_short_addr, sfr_short_mode,
                          sfr_ext_space, sas_pkg::PA_RESULT2,
                          sas_pkg::SA_RESULT2, 1'b1);
  wire hit_eoc  = sas_hit(sfr_phys_addr, sfr_short_addr, sfr_short_mode,
                          sfr_ext_space, sas_pkg::PA_EOC_IC,
                          sas_pkg::SA_EOC_IC, 1'b0);
  wire hit_ovr  = sas_hit(sfr_phys_addr, sfr_short_addr, sfr_short_mode,
                          sfr_ext_space, sas_pkg::PA_OVR_IC,
                          sas_pkg::SA_OVR_IC, 1'b0);
  wire hit_ctl  = sas_hit(sfr_phys_addr, sfr_short_addr, sfr_short_mode,
                          sfr_ext_space, sas_pkg::PA_CONTROL,
                          sas_pkg::SA_CONTROL, 1'b0);

  wire wr_ctl   = sfr_wr && hit_ctl;
  wire wr_eoc   = sfr_wr && hit_eoc;
  wire wr_ovr   = sfr_wr && hit_ovr;
  wire rd_res   = sfr_rd && hit_res;

  // Control fields
  wire [4:0] cfg_ch  = ctrl_r[sas_pkg::CTL_CH_LSB +: sas_pkg::CTL_CH_W];
  wire [1:0] cfg_mode = ctrl_r[sas_pkg::CTL_MODE_LSB +: 2];
  wire       cfg_start = ctrl_r[sas_pkg::CTL_START];
  wire       cfg_wait  = ctrl_r[sas_pkg::CTL_WAIT_RD];
  wire       cfg_inj   = ctrl_r[sas_pkg::CTL_INJ_EN];
  wire [1:0] cfg_ctc   = ctrl_r[sas_pkg::CTL_CTC_LSB +: 2];
  wire [1:0] cfg_stc   = ctrl_r[sas_pkg::CTL_STC_LSB +: 2];
  wire       mode_scan = (cfg_mode == sas_pkg::MODE_SCAN) ||
                         (cfg_mode == sas_pkg::MODE_SCAN_CONT);
  wire       mode_cont = (cfg_mode == sas_pkg::MODE_SINGLE_CONT) ||
                         (cfg_mode == sas_pkg::MODE_SCAN_CONT);
  wire       busy      = (state_r != sas_pkg::ST_IDLE);

  wire [11:0] sample_cyc = 12'({10'h000, cfg_stc} + 12'h001) *
                           SAMPLE_UNIT;
  wire [11:0] bit_cyc    = 12'({10'h000, cfg_ctc} + 12'h001) *
                           BIT_UNIT;

  // Result path through the buffer
  logic        fifo_in_valid;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic        fifo_out_ready;
  logic [15:0] fifo_out_data;
  wire  [15:0] conv_word = {cur_ch_r[3:0], 2'b00, dac_code_r};

  assign fifo_in_valid  = (state_r == sas_pkg::ST_DONE) && !inj_active_r;
  assign fifo_out_ready = !cfg_wait || !unread_r;
  wire   load_res       = fifo_out_valid && fifo_out_ready;
  wire   load_res2      = (state_r == sas_pkg::ST_DONE) && inj_active_r;
  wire   overrun        = load_res && unread_r && !rd_res;

  // Start gate: wait mode holds off while any result is pending
  wire can_start = cfg_start && fifo_in_ready &&
                   !(cfg_wait && (unread_r || fifo_out_valid));

  sas_fifo #(
    .WIDTH (16),
    .DEPTH (sas_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (conv_word),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // Digital input gating
  wire [DIS_W-1:0] dis_all = {port1_digital_input_disable,
                              analog_port_digital_input_disable};

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pin_s1_r <= 24'h000000;
      pin_s2_r <= 24'h000000;
      cmp_s1_r <= 1'b0;
      cmp_s2_r <= 1'b0;
      dig_in_r <= 24'h000000;
    end else begin
      pin_s1_r <= ain_pin_in;
      pin_s2_r <= pin_s1_r;
      cmp_s1_r <= cmp_in;
      cmp_s2_r <= cmp_s1_r;
      dig_in_r <= pin_s2_r & ~dis_all;
    end
  end

  // Sequencer next-state
  assign inj_take = inj_pend_r && cfg_inj &&
                    (cfg_mode == sas_pkg::MODE_SCAN_CONT);

  always_comb begin
    state_nxt      = state_r;
    timer_nxt      = timer_r;
    bit_nxt        = bit_r;
    dac_nxt        = dac_code_r;
    cur_ch_nxt     = cur_ch_r;
    amux_nxt       = amux_ch_r;
    inj_active_nxt = inj_active_r;
    start_clr      = 1'b0;
    case (state_r)
      sas_pkg::ST_RESET_CAL: begin
        timer_nxt = timer_r - 12'h001;
        if (timer_r == 12'h000) begin
          state_nxt = sas_pkg::ST_IDLE;
        end
      end
      sas_pkg::ST_IDLE: begin
        if (can_start || (inj_take && fifo_in_ready)) begin
          state_nxt      = sas_pkg::ST_SAMPLE;
          timer_nxt      = sample_cyc - 12'h001;
          inj_active_nxt = inj_take;
          amux_nxt       = inj_take ? inj_ch_r : cur_ch_r;
        end
      end
      sas_pkg::ST_SAMPLE: begin
        timer_nxt = timer_r - 12'h001;
        if (timer_r == 12'h000) begin
          state_nxt = sas_pkg::ST_CAL;
          timer_nxt = CAL_SLOT - 12'h001;
        end
      end
      sas_pkg::ST_CAL: begin
        timer_nxt = timer_r - 12'h001;
        if (timer_r == 12'h000) begin
          state_nxt = sas_pkg::ST_CONV;
          timer_nxt = bit_cyc - 12'h001;
          bit_nxt   = 4'(MSB);
          dac_nxt   = 10'h200;
        end
      end
      sas_pkg::ST_CONV: begin
        timer_nxt = timer_r - 12'h001;
        if (timer_r == 12'h000) begin
          dac_nxt[bit_r] = cmp_s2_r;
          timer_nxt      = bit_cyc - 12'h001;
          if (bit_r == 4'h0) begin
            state_nxt = sas_pkg::ST_DONE;
          end else begin
            bit_nxt              = bit_r - 4'h1;
            dac_nxt[bit_r - 4'h1] = 1'b1;
          end
        end
      end
      sas_pkg::ST_DONE: begin
        if (inj_active_r) begin
          state_nxt      = sas_pkg::ST_IDLE;
          inj_active_nxt = 1'b0;
        end else if (fifo_in_ready) begin
          state_nxt = sas_pkg::ST_IDLE;
          if (mode_scan) begin
            if (cur_ch_r == 5'h00) begin
              cur_ch_nxt = cfg_ch;
              start_clr  = !mode_cont;
            end else begin
              cur_ch_nxt = cur_ch_r - 5'h01;
            end
          end else begin
            start_clr = !mode_cont;
          end
        end
      end
      default: begin
        state_nxt = sas_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_r      <= sas_pkg::ST_RESET_CAL;
      timer_r      <= RESET_CAL;
      bit_r        <= 4'h0;
      dac_code_r   <= 10'h000;
      amux_ch_r    <= 5'h00;
      inj_active_r <= 1'b0;
      sample_en_r  <= 1'b0;
      cal_en_r     <= 1'b1;
    end else begin
      state_r      <= state_nxt;
      timer_r      <= timer_nxt;
      bit_r        <= bit_nxt;
      dac_code_r   <= dac_nxt;
      amux_ch_r    <= amux_nxt;
      inj_active_r <= inj_active_nxt;
      sample_en_r  <= (state_nxt == sas_pkg::ST_SAMPLE);
      cal_en_r     <= (state_nxt == sas_pkg::ST_CAL) ||
                      (state_nxt == sas_pkg::ST_RESET_CAL);
    end
  end

  // Scan channel pointer reloads on a control write when idle
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cur_ch_r <= 5'h00;
    end else if (wr_ctl && !busy) begin
      cur_ch_r <= sfr_wdata[sas_pkg::CTL_CH_LSB +: sas_pkg::CTL_CH_W];
    end else begin
      cur_ch_r <= cur_ch_nxt;
    end
  end

  // Injection request latch; a new request beats the take
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      inj_pend_r <= 1'b0;
      inj_ch_r   <= 5'h00;
    end else if (inject_req && cfg_inj &&
                 (cfg_mode == sas_pkg::MODE_SCAN_CONT)) begin
      inj_pend_r <= 1'b1;
      inj_ch_r   <= inject_ch;
    end else if (inj_take && (state_r == sas_pkg::ST_IDLE) &&
                 fifo_in_ready) begin
      inj_pend_r <= 1'b0;
    end
  end

  // Control register; busy bit is status only
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl_r <= sas_pkg::RST_CONTROL;
    end else if (wr_ctl) begin
      ctrl_r <= sfr_wdata & ~(16'h0001 << sas_pkg::CTL_BUSY);
    end else if (start_clr) begin
      ctrl_r[sas_pkg::CTL_START] <= 1'b0;
    end
  end

  // Result registers and unread indication
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      result_r  <= sas_pkg::RST_RESULT;
      result2_r <= sas_pkg::RST_RESULT2;
      unread_r  <= 1'b0;
    end else begin
      if (load_res) begin
        result_r <= fifo_out_data;
      end
      if (load_res2) begin
        result2_r <= {amux_ch_r[3:0], 2'b00, dac_code_r};
      end
      unread_r <= load_res || (unread_r && !rd_res);
    end
  end

  // Interrupt control registers; hardware set wins over write
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      eoc_ic_r <= sas_pkg::RST_EOC_IC;
      ovr_ic_r <= sas_pkg::RST_OVR_IC;
    end else begin
      if (wr_eoc) begin
        eoc_ic_r <= sfr_wdata;
      end
      if (load_res || load_res2) begin
        eoc_ic_r[sas_pkg::IC_FLAG] <= 1'b1;
      end
      if (wr_ovr) begin
        ovr_ic_r <= sfr_wdata;
      end
      if (overrun && !cfg_wait) begin
        ovr_ic_r[sas_pkg::IC_FLAG] <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      eoc_irq_r            <= 1'b0;
      ovr_irq_r            <= 1'b0;
      event_transfer_req_r <= 1'b0;
    end else begin
      eoc_irq_r <= eoc_ic_r[sas_pkg::IC_FLAG] && eoc_ic_r[sas_pkg::IC_EN];
      ovr_irq_r <= ovr_ic_r[sas_pkg::IC_FLAG] && ovr_ic_r[sas_pkg::IC_EN];
      event_transfer_req_r <= load_res || load_res2;
    end
  end

  // Read data mux
  wire [15:0] ctrl_view = ctrl_r | (16'(busy) << sas_pkg::CTL_BUSY);
  wire [15:0] rd_mux = hit_res  ? result_r  :
                       hit_res2 ? result2_r :
                       hit_eoc  ? eoc_ic_r  :
                       hit_ovr  ? ovr_ic_r  :
                       hit_ctl  ? ctrl_view : 16'h0000;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sfr_rdata_r <= 16'h0000;
    end else if (sfr_rd) begin
      sfr_rdata_r <= rd_mux;
    end
  end

endmodule : sas_adc_sequencer

// ===== verif/sas_amux_model.sv
`timescale 1ns/1ps
module sas_amux_model (
  input  wire logic       core_clk,
  input  wire logic [4:0] amux_ch_r,
  input  wire logic       sample_en_r,
  input  wire logic [9:0] dac_code_r,
  output logic            cmp_in
);
  logic [9:0] held_r = 10'h000;

  // Capacitor follows the selected channel only while sampling
  always_ff @(posedge core_clk) begin
    if (sample_en_r) begin
      held_r <= 10'(amux_ch_r * 10'h029 + 10'h00D);
    end
  end

  assign cmp_in = held_r >= dac_code_r;
endmodule : sas_amux_model

// ===== verif/sas_adc_sequencer_sva.sv
`timescale 1ns/1ps
module sas_adc_sequencer_sva (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic [15:0] sfr_phys_addr,
  input wire logic        sfr_short_mode,
  input wire logic        sfr_rd,
  input wire logic [15:0] sfr_rdata_r,
  input wire logic [23:0] ain_pin_in,
  input wire logic [15:0] analog_port_digital_input_disable,
  input wire logic [7:0]  port1_digital_input_disable,
  input wire logic [23:0] dig_in_r,
  input wire logic [4:0]  amux_ch_r,
  input wire logic        sample_en_r,
  input wire logic        cal_en_r,
  input wire logic        eoc_irq_r,
  input wire logic        ovr_irq_r,
  input wire logic        event_transfer_req_r
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  wire [23:0] din_w;
  assign din_w = ain_pin_in & ~{port1_digital_input_disable,
                                analog_port_digital_input_disable};

  property p_cal_reset; $rose(rst_n) |-> cal_en_r[*8]; endproperty
  a_cal_reset: assert property (p_cal_reset)
    else $error("calibration window missing after reset");
  property p_sample_len; $rose(sample_en_r) |-> sample_en_r[*8]; endproperty
  a_sample_len: assert property (p_sample_len)
    else $error("sample phase shorter than one unit");
  property p_cal_slot; $fell(sample_en_r) |-> cal_en_r; endproperty
  a_cal_slot: assert property (p_cal_slot)
    else $error("calibration slot not after sampling");
  property p_evt_pulse; event_transfer_req_r |=> !event_transfer_req_r;
  endproperty
  a_evt_pulse: assert property (p_evt_pulse)
    else $error("transfer request longer than one cycle");
  property p_mux_hold;
    sample_en_r && $past(sample_en_r) |-> $stable(amux_ch_r);
  endproperty
  a_mux_hold: assert property (p_mux_hold)
    else $error("mux channel moved while sampling");
  property p_ch_range; amux_ch_r < 5'h18; endproperty
  a_ch_range: assert property (p_ch_range)
    else $error("mux channel out of range");
  property p_rdata_hold; !sfr_rd |=> $stable(sfr_rdata_r); endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data changed without a read");
  property p_unmapped;
    sfr_rd && !sfr_short_mode && sfr_phys_addr == 16'hFE00
      |=> sfr_rdata_r == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_dig_in; (rst_n && $stable(din_w))[*5] |-> dig_in_r == din_w;
  endproperty
  a_dig_in: assert property (p_dig_in)
    else $error("digital input not pin gated by disable");

  c_event: cover property (event_transfer_req_r);
  c_ovr: cover property ($rose(ovr_irq_r));
  c_eoc: cover property ($rose(eoc_irq_r));
endmodule : sas_adc_sequencer_sva

bind sas_adc_sequencer sas_adc_sequencer_sva i_sva (
  .core_clk(core_clk), .rst_n(rst_n), .sfr_phys_addr(sfr_phys_addr),
  .sfr_short_mode(sfr_short_mode), .sfr_rd(sfr_rd),
  .sfr_rdata_r(sfr_rdata_r), .ain_pin_in(ain_pin_in),
  .analog_port_digital_input_disable(analog_port_digital_input_disable),
  .port1_digital_input_disable(port1_digital_input_disable),
  .dig_in_r(dig_in_r), .amux_ch_r(amux_ch_r), .sample_en_r(sample_en_r),
  .cal_en_r(cal_en_r), .eoc_irq_r(eoc_irq_r), .ovr_irq_r(ovr_irq_r),
  .event_transfer_req_r(event_transfer_req_r)
);

// ===== verif/sas_adc_sequencer_tb.sv
`timescale 1ns/1ps
module sas_adc_sequencer_tb;
  logic        core_clk = 1'b0;
  logic        rst_n    = 1'b0;
  logic [15:0] pa       = 16'h0000;
  logic [7:0]  sa       = 8'h00;
  logic        sm       = 1'b0;
  logic        ex       = 1'b0;
  logic        wr       = 1'b0;
  logic        rd       = 1'b0;
  logic [15:0] wd       = 16'h0000;
  logic        ireq     = 1'b0;
  logic [4:0]  ich      = 5'h00;
  logic [23:0] ain      = 24'h000000;
  logic [15:0] dis5     = 16'h0000;
  logic [7:0]  dis1     = 8'h00;
  logic        cmp;
  logic [15:0] rdq;
  logic [23:0] dig;
  logic [4:0]  ch;
  logic        smp;
  logic        cal;
  logic [9:0]  dac;
  logic        eoc;
  logic        ovr;
  logic        etr;
  int          n_mismatch = 0;
  int          num_checks = 0;
  int          cyc        = 0;

  sas_adc_sequencer i_dut (
    .core_clk(core_clk), .rst_n(rst_n), .sfr_phys_addr(pa),
    .sfr_short_addr(sa), .sfr_short_mode(sm), .sfr_ext_space(ex),
    .sfr_wr(wr), .sfr_rd(rd), .sfr_wdata(wd), .sfr_rdata_r(rdq),
    .inject_req(ireq), .inject_ch(ich), .cmp_in(cmp), .ain_pin_in(ain),
    .analog_port_digital_input_disable(dis5),
    .port1_digital_input_disable(dis1), .dig_in_r(dig), .amux_ch_r(ch),
    .sample_en_r(smp), .cal_en_r(cal), .dac_code_r(dac),
    .eoc_irq_r(eoc), .ovr_irq_r(ovr), .event_transfer_req_r(etr)
  );
  sas_amux_model i_amux (
    .core_clk(core_clk), .amux_ch_r(ch), .sample_en_r(smp),
    .dac_code_r(dac), .cmp_in(cmp)
  );

  always #4 core_clk = ~core_clk;

  function automatic logic [15:0] exp_res(input int c);
    return {4'(c), 2'b00, 10'(c * 10'h029 + 10'h00D)};
  endfunction : exp_res

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      test_done;
    end
  end

  task automatic chk(input string nm, input logic [23:0] seen,
                     input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One register access; read data is settled on return
  task automatic acc(input logic r, input logic s, input logic e,
                     input logic [15:0] a, input logic [15:0] d);
    @(negedge core_clk);
    rd = r;
    wr = !r;
    sm = s;
    ex = e;
    pa = a;
    sa = a[7:0];
    wd = d;
    @(negedge core_clk);
    rd = 1'b0;
    wr = 1'b0;
    @(negedge core_clk);
  endtask : acc

  task automatic wait_ev(input logic want);
    logic got;
    got = 1'b0;
    for (int i = 0; i < 300 && !got; i++) begin
      @(negedge core_clk);
      got = (etr === 1'b1);
    end
    chk("result event", got, want);
  endtask : wait_ev

  task automatic stop_conv;
    acc(0, 0, 0, sas_pkg::PA_CONTROL, 16'h0000);
    repeat (150) @(negedge core_clk);
    acc(1, 0, 0, sas_pkg::PA_RESULT, 16'h0000);
  endtask : stop_conv

  task automatic t_reset;
    logic [15:0] adr [6];
    logic [15:0] rst [6];
    int          n;
    adr = '{sas_pkg::PA_RESULT, sas_pkg::PA_RESULT2, sas_pkg::PA_EOC_IC,
            sas_pkg::PA_OVR_IC, sas_pkg::PA_CONTROL, 16'hFE00};
    rst = '{sas_pkg::RST_RESULT, sas_pkg::RST_RESULT2, sas_pkg::RST_EOC_IC,
            sas_pkg::RST_OVR_IC, sas_pkg::RST_CONTROL, 16'h0000};
    n = 0;
    chk("cal after reset", cal, 1);
    while (cal === 1'b1 && n < 3000) begin
      @(negedge core_clk);
      n++;
    end
    chk("reset cal length", 24'(n), 24'(sas_pkg::RESET_CAL_CYC + 1));
    for (int i = 0; i < 6; i++) begin
      acc(1, 0, 0, adr[i], 16'h0000);
      chk("reset value", rdq, rst[i]);
    end
  endtask : t_reset

  task automatic t_single;
    acc(0, 1, 0, sas_pkg::SA_EOC_IC, 16'h0040);
    acc(0, 1, 0, sas_pkg::SA_CONTROL, 16'h5085);
    // Doubled sample and bit times push the result past 90 cycles
    repeat (90) @(negedge core_clk);
    chk("timed conv", eoc, 0);
    wait_ev(1);
    acc(1, 1, 0, sas_pkg::SA_RESULT, 16'h0000);
    chk("single result", rdq, exp_res(5));
    chk("eoc irq", eoc, 1);
    acc(1, 0, 0, sas_pkg::PA_CONTROL, 16'h0000);
    chk("start busy", rdq & 16'h0180, 0);
    wait_ev(0);
    acc(0, 0, 0, sas_pkg::PA_EOC_IC, 16'h0080);
    chk("masked eoc", eoc, 0);
    acc(0, 0, 0, sas_pkg::PA_EOC_IC, 16'h0000);
  endtask : t_single

  task automatic t_overrun;
    acc(0, 0, 0, sas_pkg::PA_OVR_IC, 16'h0040);
    acc(0, 0, 0, sas_pkg::PA_CONTROL, 16'h00A2);
    wait_ev(1);
    wait_ev(1);
    repeat (3) @(negedge core_clk);
    chk("overrun irq", ovr, 1);
    stop_conv;
    acc(0, 0, 0, sas_pkg::PA_OVR_IC, 16'h0040);
  endtask : t_overrun

  task automatic t_wait;
    acc(0, 0, 0, sas_pkg::PA_CONTROL, 16'h02A1);
    wait_ev(1);
    wait_ev(0);
    acc(1, 0, 0, sas_pkg::PA_RESULT, 16'h0000);
    chk("held result", rdq, exp_res(1));
    wait_ev(1);
    chk("no overrun", ovr, 0);
    stop_conv;
  endtask : t_wait

  task automatic t_scan;
    acc(0, 0, 0, sas_pkg::PA_CONTROL, 16'h00C3);
    for (int i = 3; i >= 0; i--) begin
      wait_ev(1);
      acc(1, 0, 0, sas_pkg::PA_RESULT, 16'h0000);
      chk("scan result", rdq, exp_res(i));
    end
    wait_ev(0);
  endtask : t_scan

  task automatic t_inject;
    acc(0, 0, 0, sas_pkg::PA_CONTROL, 16'h04E2);
    wait_ev(1);
    ireq = 1'b1;
    ich = 5'h07;
    @(negedge core_clk);
    ireq = 1'b0;
    repeat (5) wait_ev(1);
    acc(1, 1, 1, sas_pkg::SA_RESULT2, 16'h0000);
    chk("injected result", rdq, exp_res(7));
    acc(1, 1, 0, sas_pkg::SA_RESULT, 16'h0000);
    chk("resumed scan", rdq, exp_res(1));
    stop_conv;
  endtask : t_inject

  task automatic t_digin;
    for (int i = 0; i < 2; i++) begin
      @(negedge core_clk);
      ain = i ? 24'h5A3C0F : 24'hA5C3F0;
      dis5 = i ? 16'hF00F : 16'h00FF;
      dis1 = i ? 8'hF0 : 8'h0F;
      repeat (5) @(negedge core_clk);
      chk("digital in", dig, ain & ~{dis1, dis5});
    end
  endtask : t_digin

  initial begin
    repeat (6) @(negedge core_clk);
    rst_n = 1'b1;
    t_reset;
    t_single;
    t_overrun;
    t_wait;
    t_scan;
    t_inject;
    t_digin;
    test_done;
  end
endmodule : sas_adc_sequencer_tb
